/* inc/dpm_defs.svh */
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

// register byte offsets
`define DPM_REG_CTRL 8'h00
`define DPM_REG_TIMER 8'h04
`define DPM_REG_WAKE 8'h08
`define DPM_REG_SUSP 8'h0C
`define DPM_REG_DEBOUNCE 8'h10
`define DPM_REG_STATUS 8'h14

// control register fields
`define DPM_CTRL_SOFT_STANDBY 4
`define DPM_CTRL_SOFT_SUSPEND 3

// timer register fields
`define DPM_TMR_MIN_MSB 3
`define DPM_TMR_MIN_LSB 0
`define DPM_TMR_ENABLE 4

// wake and clock register fields
`define DPM_WAKE_ACTIVITY 6
`define DPM_WAKE_HOST 5
`define DPM_WAKE_SLOW_SEL 4
`define DPM_WAKE_CLK_STOP 2
`define DPM_WAKE_SELF_REFRESH 0

// suspend register fields
`define DPM_SUSP_KEYBOARD 5
`define DPM_SUSP_POLARITY 3
`define DPM_SUSP_REF_OSC_DIS 2

// debounce register field
`define DPM_DEB_MSB 7
`define DPM_DEB_LSB 4

// reset values
`define DPM_RST_CTRL 8'h00
`define DPM_RST_TIMER 8'h00
`define DPM_RST_WAKE 8'h10
`define DPM_RST_SUSP 8'h08
`define DPM_RST_DEBOUNCE 8'h00

// timing
`define DPM_CLK_KHZ 125000
`define DPM_TICK_MS 1
`define DPM_MINUTE_MS 60000
`define DPM_PD_BIAS_MS 96
`define DPM_SEQ_STEP_MS 32
`define DPM_REF_DIV 432

`endif

/* inc/dpm_pkg.sv */
package dpm_pkg;

    typedef enum logic [2:0] {
        DPM_ON,
        DPM_PD_BIAS,
        DPM_PD_CTRL,
        DPM_OFF,
        DPM_PU_CLK,
        DPM_PU_LOGIC,
        DPM_PU_CTRL
    } dpm_state_type;

    typedef struct packed {
        logic panel_logic_power;
        logic panel_ctrl_enable;
        logic panel_bias_power;
        logic backlight_enable;
    } dpm_panel_type;

    typedef struct packed {
        logic video_dot_clock_stop;
        logic mclk_div6;
        logic mclk_stop;
        logic crtc_clk_gate;
        logic ref_osc_stop;
    } dpm_clk_type;

endpackage

/* rtl/dpm_countdown.sv */
`timescale 1ns/100ps
`default_nettype none

// loadable down counter; stops at zero
module dpm_countdown #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic step,
    input wire logic hold,
    output logic [W-1:0] count_q,
    output logic zero
);

    assign zero = (count_q == '0);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (step && !hold && !zero) begin
            count_q <= count_q - W'(1);
        end
    end

endmodule // dpm_countdown

`default_nettype wire

/* rtl/dpm_power_manager.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"

// Operation
// - inactivity timer 1..16 minutes starts standby
// - soft standby bit set starts standby
// - standby pin high starts standby
// - standby holds until all requests gone
// - activity input reloads timer when enabled
// - host access reloads timer when enabled
// - keyboard reloads timer, not in PI mode
// - clearing soft standby bit withdraws request
// - standby pin low withdraws hardware request
// - running panel sequence finishes before new request
// - standby stops video clock, mclk div six
// - leaving standby powers panel back up
// - ac power hold freezes inactivity timers
// - suspend pin polarity select and debounce
// - hardware suspend with clock-stop bit refuses host access
// - hardware suspend with clock-stop bit deactivates all other pins
// - slow clock: reference/432 or external
// - reference oscillator stop with external slow clock
// - hardware suspend refresh at slow rate unless self-refresh
// - hardware suspend stops clocks only with clock-stop bit
// - clock-stop zero: cover closed, clocks run
// - soft suspend keeps access, ignores pin
// - suspend ends on pin inactive or bit clear
// - power-down: bias off, 96ms, ctrl, 32ms, logic
// - power-up: clock, 32ms steps logic, ctrl, bias
module dpm_power_manager
    import dpm_pkg::*;
#(
    parameter int MS_CYCLES = `DPM_TICK_MS * `DPM_CLK_KHZ,
    parameter int MINUTE_MS = `DPM_MINUTE_MS,
    parameter int PD_BIAS_MS = `DPM_PD_BIAS_MS,
    parameter int SEQ_STEP_MS = `DPM_SEQ_STEP_MS,
    parameter int REF_DIV = `DPM_REF_DIV
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic standby_req_pin,
    input wire logic suspend_req_pin,
    input wire logic activity_input,
    input wire logic host_access,
    input wire logic keyboard_access,
    input wire logic pi_bus_mode,
    input wire logic ac_power_hold,
    input wire logic ref_clk_en,
    input wire logic ext_slow_clk,
    output dpm_panel_type panel_q,
    output dpm_clk_type clk_ctl_q,
    output logic host_access_en_q,
    output logic io_pins_off_q,
    output logic slow_refresh_q,
    output logic refresh_tick_q
);

    localparam int MS_W = $clog2(MS_CYCLES + 1);
    localparam int MIN_W = $clog2(MINUTE_MS + 1);
    localparam int REF_W = $clog2(REF_DIV + 1);

    logic [7:0] ctrl_q;
    logic [7:0] tmr_q;
    logic [7:0] wake_q;
    logic [7:0] susp_q;
    logic [7:0] deb_q;
    logic ack_q;
    logic err_q;
    logic [31:0] rdat_q;
    dpm_state_type state_q;
    dpm_state_type state_d;
    logic expired_q;
    logic hw_susp_q;
    logic ext_slow_q;

    // bus decode; busy until the answer has left, so a strobe held to the ack edge is not taken twice
    wire acc = wb_cyc_i && wb_stb_i && !ack_q && !err_q && !wb_ack_o && !wb_err_o;
    wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
    wire hit_ctrl = (word_adr == `DPM_REG_CTRL);
    wire hit_tmr = (word_adr == `DPM_REG_TIMER);
    wire hit_wake = (word_adr == `DPM_REG_WAKE);
    wire hit_susp = (word_adr == `DPM_REG_SUSP);
    wire hit_deb = (word_adr == `DPM_REG_DEBOUNCE);
    wire hit_stat = (word_adr == `DPM_REG_STATUS);
    wire refuse = !host_access_en_q;
    wire wr = acc && wb_we_i && wb_sel_i[0] && !refuse;

    // configuration fields
    wire soft_standby_bit = ctrl_q[`DPM_CTRL_SOFT_STANDBY];
    wire soft_suspend_bit = ctrl_q[`DPM_CTRL_SOFT_SUSPEND];
    wire [3:0] standby_minutes = tmr_q[`DPM_TMR_MIN_MSB:`DPM_TMR_MIN_LSB];
    wire standby_timer_enable = tmr_q[`DPM_TMR_ENABLE];
    wire activity_pin_wake_enable = wake_q[`DPM_WAKE_ACTIVITY];
    wire host_access_wake_enable = wake_q[`DPM_WAKE_HOST];
    wire internal_slow_clock_select = wake_q[`DPM_WAKE_SLOW_SEL];
    wire suspend_clock_stop = wake_q[`DPM_WAKE_CLK_STOP];
    wire self_refresh_mem = wake_q[`DPM_WAKE_SELF_REFRESH];
    wire keyboard_wake_enable = susp_q[`DPM_SUSP_KEYBOARD];
    wire suspend_polarity = susp_q[`DPM_SUSP_POLARITY];
    wire reference_osc_disable = susp_q[`DPM_SUSP_REF_OSC_DIS];
    wire [3:0] suspend_debounce = deb_q[`DPM_DEB_MSB:`DPM_DEB_LSB];

    // time base
    logic [MS_W-1:0] ms_cnt;
    logic ms_zero;
    logic [MIN_W-1:0] min_cnt;
    logic min_zero;
    wire ms_tick = ms_zero;
    wire minute_tick = min_zero && ms_tick;

    dpm_countdown #(.W(MS_W)) u_ms_pre (
        .clk(clk),
        .rstn(rstn),
        .load(ms_zero),
        .load_val(MS_W'(MS_CYCLES - 1)),
        .step(1'b1),
        .hold(1'b0),
        .count_q(ms_cnt),
        .zero(ms_zero)
    );

    dpm_countdown #(.W(MIN_W)) u_min_pre (
        .clk(clk),
        .rstn(rstn),
        .load(min_zero && ms_tick),
        .load_val(MIN_W'(MINUTE_MS - 1)),
        .step(ms_tick),
        .hold(1'b0),
        .count_q(min_cnt),
        .zero(min_zero)
    );

    // inactivity timer; counts field + 1 minutes, so 15 gives 16 minutes
    wire reload_act = activity_pin_wake_enable && activity_input;
    wire reload_host = host_access_wake_enable && (host_access || acc);
    wire reload_kb = keyboard_wake_enable && keyboard_access && !pi_bus_mode;
    wire tmr_reload = reload_act || reload_host || reload_kb || (wr && hit_tmr);
    logic [4:0] sby_cnt;
    logic sby_zero;

    dpm_countdown #(.W(5)) u_standby_tmr (
        .clk(clk),
        .rstn(rstn),
        .load(tmr_reload),
        .load_val({1'b0, standby_minutes} + 5'h01),
        .step(minute_tick),
        .hold(ac_power_hold),
        .count_q(sby_cnt),
        .zero(sby_zero)
    );

    // suspend pin: polarity then debounce in 1 ms steps
    wire susp_active = (suspend_req_pin == suspend_polarity);
    logic [3:0] deb_cnt;
    logic deb_zero;

    dpm_countdown #(.W(4)) u_debounce (
        .clk(clk),
        .rstn(rstn),
        .load(!susp_active),
        .load_val(suspend_debounce),
        .step(ms_tick),
        .hold(1'b0),
        .count_q(deb_cnt),
        .zero(deb_zero)
    );

    // request combination
    wire sby_req = expired_q || soft_standby_bit || standby_req_pin;
    wire hw_susp = hw_susp_q && !soft_suspend_bit;
    wire susp_req = hw_susp || soft_suspend_bit;
    wire down_req = sby_req || susp_req;
    wire hw_stop = hw_susp && suspend_clock_stop;
    wire cover_only = hw_susp && !suspend_clock_stop && !sby_req;
    wire is_off = (state_q == DPM_OFF);

    // panel sequence; requests are looked at only in the settled states
    logic [6:0] seq_cnt;
    logic seq_zero;
    logic [6:0] seq_wait;

    always_comb begin
        state_d = state_q;
        case (state_q)
            DPM_ON: begin
                if (down_req) begin
                    state_d = DPM_PD_BIAS;
                end
            end
            DPM_PD_BIAS: begin
                if (seq_zero) begin
                    state_d = DPM_PD_CTRL;
                end
            end
            DPM_PD_CTRL: begin
                if (seq_zero) begin
                    state_d = DPM_OFF;
                end
            end
            DPM_OFF: begin
                if (!down_req) begin
                    state_d = DPM_PU_CLK;
                end
            end
            DPM_PU_CLK: begin
                if (seq_zero) begin
                    state_d = DPM_PU_LOGIC;
                end
            end
            DPM_PU_LOGIC: begin
                if (seq_zero) begin
                    state_d = DPM_PU_CTRL;
                end
            end
            DPM_PU_CTRL: begin
                if (seq_zero) begin
                    state_d = DPM_ON;
                end
            end
            default: begin
                state_d = DPM_ON;
            end
        endcase
    end

    assign seq_wait = (state_d == DPM_PD_BIAS) ? 7'(PD_BIAS_MS) : 7'(SEQ_STEP_MS);

    dpm_countdown #(.W(7)) u_seq_wait (
        .clk(clk),
        .rstn(rstn),
        .load(state_d != state_q),
        .load_val(seq_wait),
        .step(ms_tick),
        .hold(1'b0),
        .count_q(seq_cnt),
        .zero(seq_zero)
    );

    // slow refresh clock
    logic [REF_W-1:0] ref_cnt;
    logic ref_zero;
    wire ref_tick = ref_zero && ref_clk_en;
    wire ext_edge = ext_slow_clk && !ext_slow_q;
    wire slow_tick = internal_slow_clock_select ? ref_tick : ext_edge;
    wire slow_mode = is_off && hw_susp && !self_refresh_mem;

    dpm_countdown #(.W(REF_W)) u_ref_div (
        .clk(clk),
        .rstn(rstn),
        .load(ref_tick),
        .load_val(REF_W'(REF_DIV - 1)),
        .step(ref_clk_en),
        .hold(1'b0),
        .count_q(ref_cnt),
        .zero(ref_zero)
    );

    // read mux
    wire [7:0] status = {2'b00, expired_q, hw_susp, sby_req,
        (state_q != DPM_ON) && !is_off, is_off, state_q == DPM_ON};
    wire [7:0] rd_byte = hit_ctrl ? ctrl_q :
        hit_tmr ? tmr_q :
        hit_wake ? wake_q :
        hit_susp ? susp_q :
        hit_deb ? deb_q :
        hit_stat ? status : 8'h00;

    // bus answer: ack two cycles after request, err while refused
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= acc && !refuse;
            err_q <= acc && refuse;
            rdat_q <= (acc && !refuse && !wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // registers; content is kept through suspend
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= `DPM_RST_CTRL;
            tmr_q <= `DPM_RST_TIMER;
            wake_q <= `DPM_RST_WAKE;
            susp_q <= `DPM_RST_SUSP;
            deb_q <= `DPM_RST_DEBOUNCE;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_q <= wb_dat_i[7:0];
            end
            if (hit_tmr) begin
                tmr_q <= wb_dat_i[7:0];
            end
            if (hit_wake) begin
                wake_q <= wb_dat_i[7:0];
            end
            if (hit_susp) begin
                susp_q <= wb_dat_i[7:0];
            end
            if (hit_deb) begin
                deb_q <= wb_dat_i[7:0];
            end
        end
    end

    // request flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            expired_q <= 1'b0;
            hw_susp_q <= 1'b0;
            ext_slow_q <= 1'b0;
        end else begin
            expired_q <= standby_timer_enable && sby_zero && !tmr_reload;
            hw_susp_q <= susp_active && deb_zero;
            ext_slow_q <= ext_slow_clk;
        end
    end

    // state and outputs; every output leaves a flop
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= DPM_ON;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            panel_q <= '1;
            clk_ctl_q <= '0;
            host_access_en_q <= 1'b1;
            io_pins_off_q <= 1'b0;
            slow_refresh_q <= 1'b0;
            refresh_tick_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wb_ack_o <= ack_q;
            wb_err_o <= err_q;
            wb_dat_o <= rdat_q;
            panel_q.backlight_enable <= (state_q == DPM_ON);
            panel_q.panel_bias_power <= (state_q == DPM_ON);
            panel_q.panel_ctrl_enable <= (state_q == DPM_ON) || (state_q == DPM_PD_BIAS)
                || (state_q == DPM_PU_CTRL);
            panel_q.panel_logic_power <= !is_off && (state_q != DPM_PU_CLK);
            // cover-closed keeps the dot clock running at the cost of power
            clk_ctl_q.video_dot_clock_stop <= is_off && !cover_only;
            clk_ctl_q.mclk_div6 <= is_off && sby_req && !hw_stop;
            clk_ctl_q.mclk_stop <= is_off && hw_stop;
            clk_ctl_q.crtc_clk_gate <= is_off && sby_req;
            clk_ctl_q.ref_osc_stop <= reference_osc_disable && !internal_slow_clock_select;
            host_access_en_q <= !(is_off && hw_stop);
            io_pins_off_q <= is_off && hw_stop;
            slow_refresh_q <= slow_mode;
            refresh_tick_q <= slow_mode && slow_tick;
        end
    end

endmodule // dpm_power_manager

`default_nettype wire

/* tb/dpm_power_manager_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"

// panel sequence order and bus answer checks at the top ports
module dpm_power_manager_monitor
    import dpm_pkg::*;
#(
    parameter int MS_CYCLES = `DPM_TICK_MS * `DPM_CLK_KHZ,
    parameter int PD_BIAS_MS = `DPM_PD_BIAS_MS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire dpm_panel_type panel_q,
    input wire dpm_clk_type clk_ctl_q
);
    // one ms of slack each way: the sequencer steps on a ms tick of free phase
    localparam int PD_LO = (PD_BIAS_MS - 1) * MS_CYCLES - 1;
    localparam int PD_HI = (PD_BIAS_MS + 1) * MS_CYCLES + 2;
    int pd_cnt_q;
    logic pd_wait;
    assign pd_wait = panel_q.panel_ctrl_enable && !panel_q.panel_bias_power;
    always_ff @(posedge clk) begin
        if (!rstn || !pd_wait) begin
            pd_cnt_q <= 0;
        end else begin
            pd_cnt_q <= pd_cnt_q + 1;
        end
    end
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    AST_PD_ORDER: assert property ($fell(panel_q.panel_ctrl_enable) |-> !panel_q.panel_bias_power)
        else $error("control dropped with bias on");
    AST_PD_MIN: assert property ($fell(panel_q.panel_ctrl_enable) |-> pd_cnt_q >= PD_LO)
        else $error("bias to control wait too short");
    AST_PD_MAX: assert property (pd_cnt_q <= PD_HI)
        else $error("control wait too long");
    AST_PD_LOGIC: assert property ($fell(panel_q.panel_logic_power) |-> !panel_q.panel_ctrl_enable)
        else $error("logic power off before control");
    AST_DOT_STOP: assert property ($rose(clk_ctl_q.video_dot_clock_stop) |-> !panel_q.panel_logic_power)
        else $error("dot clock stopped with logic on");
    AST_PU_CTRL: assert property ($rose(panel_q.panel_ctrl_enable) |-> panel_q.panel_logic_power)
        else $error("control before logic power");
    AST_PU_BIAS: assert property ($rose(panel_q.panel_bias_power) |-> panel_q.panel_ctrl_enable)
        else $error("bias before control");
    AST_PU_CLK: assert property ($rose(panel_q.panel_logic_power) |-> !$past(clk_ctl_q.video_dot_clock_stop, 8))
        else $error("logic power without clock lead");
    AST_ERR_DATA: assert property (wb_err_o |-> wb_dat_o == 32'h0 && !wb_ack_o)
        else $error("refused access leaks data");
    AST_ANSWER: assert property (wb_cyc_i && $rose(wb_stb_i) |-> ##2 (wb_ack_o || wb_err_o))
        else $error("bus answer late");
    COV_DOWN: cover property ($fell(panel_q.backlight_enable));
    COV_UP: cover property ($rose(panel_q.backlight_enable));
    COV_ERR: cover property (wb_err_o);
endmodule // dpm_power_manager_monitor

bind dpm_power_manager dpm_power_manager_monitor #(
    .MS_CYCLES(MS_CYCLES),
    .PD_BIAS_MS(PD_BIAS_MS)
) dpm_power_manager_monitor_inst (
    .clk(clk),
    .rstn(rstn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .panel_q(panel_q),
    .clk_ctl_q(clk_ctl_q)
);
`default_nettype wire

/* tb/dpm_far_side.sv */
`timescale 1ns/100ps
`default_nettype none

// system power logic and external slow oscillator
module dpm_far_side (
    input wire logic clk,
    input wire logic want_standby,
    input wire logic want_suspend,
    output logic standby_req_pin,
    output logic suspend_req_pin,
    output logic ext_slow_clk,
    output logic ref_clk_en
);
    logic [3:0] div_q;
    initial begin
        standby_req_pin = 1'h0;
        suspend_req_pin = 1'h0;
        div_q = 4'h0;
    end
    // requests are plain levels, held until the system withdraws them
    always @(posedge clk) begin
        standby_req_pin <= want_standby;
        suspend_req_pin <= want_suspend;
        div_q <= div_q + 4'h1;
    end
    assign ext_slow_clk = div_q[3];
    // reference runs at bench clock rate, so the enable never drops
    assign ref_clk_en = 1'h1;
endmodule // dpm_far_side
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("Error %s expected %0h seen %0h", what, exp, got); end end

module tb
    import dpm_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] x;
    } dpm_row_type;
    logic clk = 1'h0, rstn = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, wb_err_o, er;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic activity_input = 1'h0, ac_power_hold = 1'h0, want_standby = 1'h0, want_suspend = 1'h0;
    logic host_access = 1'h0, keyboard_access = 1'h0, pi_bus_mode = 1'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic standby_req_pin, suspend_req_pin, ext_slow_clk, ref_clk_en;
    logic host_access_en_q, io_pins_off_q, slow_refresh_q, refresh_tick_q;
    dpm_panel_type panel_q;
    dpm_clk_type clk_ctl_q;
    int n_fail = 0, comparisons = 0, n;
    // reset values, an unmapped place, then a field written and read back
    dpm_row_type rows [9] = '{'{1'h0, 8'h00, 8'h00, 8'h00}, '{1'h0, 8'h04, 8'h00, 8'h00},
        '{1'h0, 8'h08, 8'h00, 8'h10}, '{1'h0, 8'h0C, 8'h00, 8'h08}, '{1'h0, 8'h10, 8'h00, 8'h00},
        '{1'h1, 8'h1C, 8'h5A, 8'h00}, '{1'h0, 8'h1C, 8'h00, 8'h00}, '{1'h1, 8'h10, 8'hF0, 8'h00},
        '{1'h0, 8'h10, 8'h00, 8'hF0}};

    dpm_power_manager #(.MS_CYCLES(10), .MINUTE_MS(5), .PD_BIAS_MS(3), .SEQ_STEP_MS(2)) dpm_power_manager_inst (
        .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .standby_req_pin(standby_req_pin), .suspend_req_pin(suspend_req_pin),
        .activity_input(activity_input), .host_access(host_access), .keyboard_access(keyboard_access),
        .pi_bus_mode(pi_bus_mode),
        .ac_power_hold(ac_power_hold), .ref_clk_en(ref_clk_en), .ext_slow_clk(ext_slow_clk), .panel_q(panel_q),
        .clk_ctl_q(clk_ctl_q), .host_access_en_q(host_access_en_q), .io_pins_off_q(io_pins_off_q),
        .slow_refresh_q(slow_refresh_q), .refresh_tick_q(refresh_tick_q));
    dpm_far_side dpm_far_side_inst (.clk(clk), .want_standby(want_standby), .want_suspend(want_suspend),
        .standby_req_pin(standby_req_pin), .suspend_req_pin(suspend_req_pin), .ext_slow_clk(ext_slow_clk),
        .ref_clk_en(ref_clk_en));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r,
            output logic e);
        int k;
        k = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_sel_i <= 4'h1;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        @(posedge clk);
        while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        `CHK("bus answer", 1'h1, wb_ack_o | wb_err_o)
        r = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, d, rd, er);
    endtask

    // waits for one panel enable to reach a level; bit 3 logic power, bit 0 backlight
    task automatic wait_panel(input int b, input logic v, input int lim);
        int k;
        k = 0;
        while (panel_q[b] !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        `CHK("panel level", v, panel_q[b])
    endtask

    task automatic tick_gap(output int g);
        g = 0;
        @(posedge clk);
        while (refresh_tick_q !== 1'h1 && g < 1000) begin
            @(posedge clk);
            g++;
        end
        g++;
    endtask

    initial begin
        #(8 * 20000);
        n_fail++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        `CHK("panel reset", 4'hF, panel_q)
        `CHK("clock reset", 5'h00, clk_ctl_q)
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, rd, er);
            `CHK("register", {24'h0, rows[i].x}, rd & {32{~rows[i].w}})
        end
        wr(8'h00, 8'h10);
        wait_panel(3, 1'h0, 200);
        `CHK("standby clocks", 5'h1A, clk_ctl_q)
        `CHK("standby access", 1'h1, host_access_en_q)
        want_standby <= 1'h1;
        repeat (6) @(posedge clk);
        wr(8'h00, 8'h00);
        repeat (100) @(posedge clk);
        `CHK("standby held", 4'h0, panel_q)
        want_standby <= 1'h0;
        wait_panel(0, 1'h1, 300);
        `CHK("restored clocks", 5'h00, clk_ctl_q)
        wr(8'h00, 8'h10);
        wr(8'h00, 8'h00);
        wait_panel(3, 1'h0, 200);
        wait_panel(0, 1'h1, 300);
        wr(8'h08, 8'h50);
        activity_input <= 1'h1;
        wr(8'h04, 8'h10);
        repeat (150) @(posedge clk);
        `CHK("activity reload", 1'h1, panel_q.backlight_enable)
        activity_input <= 1'h0;
        ac_power_hold <= 1'h1;
        repeat (150) @(posedge clk);
        `CHK("timer held", 1'h1, panel_q.backlight_enable)
        ac_power_hold <= 1'h0;
        wait_panel(0, 1'h0, 150);
        activity_input <= 1'h1;
        wait_panel(3, 1'h0, 200);
        wait_panel(0, 1'h1, 300);
        // host and keyboard reloads; keyboard no longer counts in PI mode
        wr(8'h08, 8'h30);
        activity_input <= 1'h0;
        host_access <= 1'h1;
        repeat (150) @(posedge clk);
        `CHK("host reload", 1'h1, panel_q.backlight_enable)
        host_access <= 1'h0;
        keyboard_access <= 1'h1;
        wr(8'h0C, 8'h28);
        repeat (150) @(posedge clk);
        `CHK("keyboard reload", 1'h1, panel_q.backlight_enable)
        pi_bus_mode <= 1'h1;
        wait_panel(0, 1'h0, 150);
        pi_bus_mode <= 1'h0;
        wait_panel(3, 1'h0, 200);
        wait_panel(0, 1'h1, 300);
        wr(8'h04, 8'h00);
        keyboard_access <= 1'h0;
        wr(8'h10, 8'h20);
        wr(8'h08, 8'h14);
        want_suspend <= 1'h1;
        repeat (5) @(posedge clk);
        want_suspend <= 1'h0;
        repeat (60) @(posedge clk);
        `CHK("short pulse", 4'hF, panel_q)
        want_suspend <= 1'h1;
        wait_panel(3, 1'h0, 300);
        `CHK("suspend access", 1'h0, host_access_en_q)
        `CHK("pins off", 1'h1, io_pins_off_q)
        `CHK("mclk stop", 1'h1, clk_ctl_q.mclk_stop)
        `CHK("slow refresh", 1'h1, slow_refresh_q)
        bus(1'h0, 8'h00, 8'h00, rd, er);
        `CHK("refused", 1'h1, er)
        tick_gap(n);
        tick_gap(n);
        `CHK("tick period", 432, n)
        want_suspend <= 1'h0;
        wait_panel(0, 1'h1, 300);
        `CHK("access back", 1'h1, host_access_en_q)
        wr(8'h00, 8'h08);
        wait_panel(3, 1'h0, 300);
        `CHK("soft access", 1'h1, host_access_en_q)
        wr(8'h00, 8'h00);
        wait_panel(0, 1'h1, 300);
        // cover-closed suspend refreshed from the external slow clock
        wr(8'h08, 8'h00);
        wr(8'h0C, 8'h0C);
        `CHK("ref osc stop", 1'h1, clk_ctl_q.ref_osc_stop)
        want_suspend <= 1'h1;
        wait_panel(3, 1'h0, 300);
        `CHK("cover access", 1'h1, host_access_en_q)
        `CHK("cover dot clock", 1'h0, clk_ctl_q.video_dot_clock_stop)
        tick_gap(n);
        tick_gap(n);
        `CHK("ext tick period", 16, n)
        want_suspend <= 1'h0;
        wait_panel(0, 1'h1, 300);
        // reset again in mid-run: registers and clock controls return
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        `CHK("clock mid reset", 5'h00, clk_ctl_q)
        bus(1'h0, 8'h0C, 8'h00, rd, er);
        `CHK("susp mid reset", 32'h08, rd)
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
